//--- hw/adcs_params.svh
`ifndef ADCS_PARAMS_SVH
`define ADCS_PARAMS_SVH

// Register word offsets
`define ADCS_REG_CTRL 4'h0
`define ADCS_REG_CHAN 4'h1
`define ADCS_REG_STAT 4'h2
`define ADCS_REG_MASK 4'h3
`define ADCS_REG_DATA 4'h4
`define ADCS_REG_CMD 4'h5

// Control register field positions
`define ADCS_CTRL_RES10 0
`define ADCS_CTRL_MODE_LO 1
`define ADCS_CTRL_MODE_HI 2
`define ADCS_CTRL_TRIG_LO 3
`define ADCS_CTRL_TRIG_HI 4
`define ADCS_CTRL_PROT 5

// Channel register fields
`define ADCS_CHAN_START_LO 0
`define ADCS_CHAN_START_HI 2
`define ADCS_CHAN_END_LO 4
`define ADCS_CHAN_END_HI 6

// Status bits
`define ADCS_ST_DONE 0
`define ADCS_ST_OVR 1
`define ADCS_ST_BUSY 2

// Command bits
`define ADCS_CMD_START 0
`define ADCS_CMD_STOP 1

// Timing: figures in ns at the reference clock
`define ADCS_CONV_NS 6130
`define ADCS_SAMPLE_NS 2000
`define ADCS_CLK_NS 8
// Least times round up
`define ADCS_SAMPLE_CYC ((`ADCS_SAMPLE_NS + `ADCS_CLK_NS - 1) / `ADCS_CLK_NS)
`define ADCS_CONV_CYC ((`ADCS_CONV_NS + `ADCS_CLK_NS - 1) / `ADCS_CLK_NS)

`define ADCS_RES_BITS 10
// Lowest trial bit in eight-bit mode
`define ADCS_NARROW_LSB 2
`define ADCS_NCHAN 8

`endif

//--- hw/adcs_pkg.sv
package adcs_pkg;
  typedef enum logic [1:0] {
    ADCS_MODE_SINGLE1,
    ADCS_MODE_SINGLE2,
    ADCS_MODE_CONT,
    ADCS_MODE_INCR
  } adcs_mode_t;

  typedef enum logic [1:0] {
    ADCS_TRIG_SW,
    ADCS_TRIG_RELOAD,
    ADCS_TRIG_FREERUN,
    ADCS_TRIG_NONE
  } adcs_trig_t;

  typedef enum logic [2:0] {
    ADCS_IDLE,
    ADCS_SAMPLE,
    ADCS_APPROX,
    ADCS_SETTLE,
    ADCS_PAUSE
  } adcs_state_t;
endpackage

//--- hw/adcs_sequencer.sv
`timescale 1ns/10ps
`include "adcs_params.svh"
// Operation
// - Software chooses eight-bit or ten-bit result per conversion.
// - Eight analog channels; program settings pick the channel range.
// - Start from software, reload timer rising edge or free-run zero edge.
// - Single-shot modes with one channel convert once, then stop.
// - Single-shot scan converts each channel once in order, then stops.
// - Continuous mode repeats conversions on one channel or the scan set.
// - Incremental mode converts one channel then waits for next trigger.
// - Completion raises interrupt usable by the descriptor transfer service.
// - With protection enabled, an unread result is never overwritten.
// - Whole conversion with sampling lasts at least 6.13 us.
// - Sampling phase lasts at least 2.0 us.
// - Result comes by successive approximation after sample and hold.
module adcs_sequencer
  import adcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic reload_timer_out,
  input wire logic freerun_zero,
  input wire logic cmp_high,
  output logic [2:0] analog_channel,
  output logic sample_hold,
  output logic [9:0] dac_code,
  output logic irq,
  output logic descriptor_transfer_service
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [5:0] ctrl;
  logic [6:0] chan_cfg;
  logic [2:0] mask;
  logic [2:0] status;
  logic [9:0] result;
  logic result_unread;
  adcs_state_t state;
  logic [9:0] timer;
  logic [3:0] bit_idx;
  logic [9:0] sar;
  logic [2:0] cur_chan;
  logic [2:0] rld_sync;
  logic [2:0] frz_sync;
  logic rld_level;
  logic frz_level;
  logic rld_prev;
  logic frz_prev;
  logic hw_trig;
  logic sw_start;
  logic sw_stop;
  logic trigger;
  logic conv_done;
  logic stored;
  logic wr_acc;
  logic rd_acc;
  logic rd_pend;
  logic next_rd_pend;
  adcs_mode_t mode;
  adcs_trig_t trig_sel;
  logic res10;
  logic prot_en;
  logic [2:0] chan_start;
  logic [2:0] chan_end;
  logic [3:0] lsb_idx;

  localparam logic [9:0] SAMPLE_CYC = 10'(`ADCS_SAMPLE_CYC);
  localparam logic [9:0] CONV_CYC = 10'(`ADCS_CONV_CYC);
  localparam logic [3:0] MSB_IDX = 4'(`ADCS_RES_BITS - 1);
  localparam logic [3:0] NARROW_LSB = 4'(`ADCS_NARROW_LSB);

  // Bit position of the one-hot trial bit for a given step
  function automatic logic [9:0] adcs_trial(input logic [3:0] idx);
    adcs_trial = 10'h001 << idx;
  endfunction

  // Trial bit survives when the input is at least the trial code
  function automatic logic [9:0] adcs_keep(input logic [9:0] code,
                                           input logic [3:0] idx,
                                           input logic keep);
    adcs_keep = keep ? code : (code & ~adcs_trial(idx));
  endfunction

  assign mode = adcs_mode_t'(ctrl[`ADCS_CTRL_MODE_HI:`ADCS_CTRL_MODE_LO]);
  assign trig_sel = adcs_trig_t'(ctrl[`ADCS_CTRL_TRIG_HI:`ADCS_CTRL_TRIG_LO]);
  assign res10 = ctrl[`ADCS_CTRL_RES10];
  assign prot_en = ctrl[`ADCS_CTRL_PROT];
  assign chan_start = chan_cfg[`ADCS_CHAN_START_HI:`ADCS_CHAN_START_LO];
  assign chan_end = chan_cfg[`ADCS_CHAN_END_HI:`ADCS_CHAN_END_LO];
  // Eight-bit mode uses the top trial bits, so full scale is kept
  assign lsb_idx = res10 ? 4'h0 : NARROW_LSB;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: writes take one cycle, reads answer one cycle later

  assign wr_acc = avs_write;
  assign rd_acc = avs_read && rd_pend;
  assign next_rd_pend = avs_read && !rd_pend;
  // Reads stall one cycle so readdata comes from a flop
  assign avs_waitrequest = avs_read && !rd_pend;
  assign sw_start = wr_acc && (avs_address == `ADCS_REG_CMD) &&
                    avs_writedata[`ADCS_CMD_START];
  assign sw_stop = wr_acc && (avs_address == `ADCS_REG_CMD) &&
                   avs_writedata[`ADCS_CMD_STOP];

  // Read pending flag
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_pend <= 1'b0;
    end else begin
      rd_pend <= next_rd_pend;
    end
  end

  // Read data mux, unmapped reads return zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
    end else if (next_rd_pend) begin
      unique case (avs_address)
        `ADCS_REG_CTRL: avs_readdata <= {26'h0, ctrl};
        `ADCS_REG_CHAN: avs_readdata <= {25'h0, chan_cfg};
        `ADCS_REG_STAT: avs_readdata <= {29'h0, status};
        `ADCS_REG_MASK: avs_readdata <= {29'h0, mask};
        `ADCS_REG_DATA: avs_readdata <= {22'h0, result};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= 6'h00;
      chan_cfg <= 7'h00;
      mask <= 3'h0;
    end else if (wr_acc) begin
      if (avs_address == `ADCS_REG_CTRL) begin
        ctrl <= avs_writedata[5:0];
      end
      if (avs_address == `ADCS_REG_CHAN) begin
        chan_cfg <= avs_writedata[6:0];
      end
      if (avs_address == `ADCS_REG_MASK) begin
        mask <= avs_writedata[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger inputs: three flops, an edge counts when stages two and three agree

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rld_sync <= 3'h0;
      frz_sync <= 3'h0;
      rld_level <= 1'b0;
      frz_level <= 1'b0;
      rld_prev <= 1'b0;
      frz_prev <= 1'b0;
    end else begin
      rld_sync <= {rld_sync[1:0], reload_timer_out};
      frz_sync <= {frz_sync[1:0], freerun_zero};
      if (rld_sync[1] == rld_sync[2]) begin
        rld_level <= rld_sync[2];
      end
      if (frz_sync[1] == frz_sync[2]) begin
        frz_level <= frz_sync[2];
      end
      rld_prev <= rld_level;
      frz_prev <= frz_level;
    end
  end

  // Rising edges only; a held level must not retrigger
  always_comb begin
    unique case (trig_sel)
      ADCS_TRIG_RELOAD: hw_trig = rld_level && !rld_prev;
      ADCS_TRIG_FREERUN: hw_trig = frz_level && !frz_prev;
      default: hw_trig = 1'b0;
    endcase
  end
  // A trigger during a conversion is dropped, not queued; queuing would
  // let a burst of timer edges run conversions back to back unnoticed
  assign trigger = sw_start || hw_trig;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer

  // Timeline of one conversion, counted in timer:
  //   1 to SAMPLE_CYC       track the input, hold at the end
  //   next 8 or 10 cycles   one trial bit per cycle, MSB first
  //   up to CONV_CYC        pad, so the least time holds at any resolution
  // The pad makes eight-bit mode no faster; only the lower bound is fixed.
  // A stop command wins over every state change, not over a store in the same cycle, and leaves the datapath as it is.
  assign conv_done = (state == ADCS_SETTLE) && (timer == CONV_CYC);
  // Stalling rather than dropping keeps the newest sample waiting, so it
  // is the one stored once software has read the old result out
  // Protection holds a finished result back while the old one is unread
  assign stored = conv_done && !(prot_en && result_unread);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ADCS_IDLE;
      timer <= 10'h000;
      cur_chan <= 3'h0;
    end else if (sw_stop) begin
      state <= ADCS_IDLE;
    end else begin
      unique case (state)
        ADCS_IDLE, ADCS_PAUSE: begin
          if (trigger) begin
            // Idle restarts the scan, pause resumes it
            if (state == ADCS_IDLE) begin
              cur_chan <= chan_start;
            end
            state <= ADCS_SAMPLE;
            timer <= 10'h001;
          end
        end
        ADCS_SAMPLE: begin
          timer <= timer + 10'h001;
          if (timer == SAMPLE_CYC) begin
            state <= ADCS_APPROX;
          end
        end
        ADCS_APPROX: begin
          timer <= timer + 10'h001;
          if (bit_idx == lsb_idx) begin
            state <= ADCS_SETTLE;
          end
        end
        ADCS_SETTLE: begin
          // Pad out to the least conversion time
          if (timer != CONV_CYC) begin
            timer <= timer + 10'h001;
          end else if (stored) begin
            timer <= 10'h001;
            if (cur_chan != chan_end) begin
              cur_chan <= cur_chan + 3'h1;
              state <= (mode == ADCS_MODE_INCR) ? ADCS_PAUSE
                                                : ADCS_SAMPLE;
            end else begin
              cur_chan <= chan_start;
              unique case (mode)
                ADCS_MODE_CONT: state <= ADCS_SAMPLE;
                ADCS_MODE_INCR: state <= ADCS_PAUSE;
                default: state <= ADCS_IDLE;
              endcase
            end
          end
        end
        default: state <= ADCS_IDLE;
      endcase
    end
  end

  // SAR datapath: trial bits from the MSB down; eight-bit mode stops two
  // bits early, so its code still spans the whole ten-bit scale
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_idx <= 4'h0;
      sar <= 10'h000;
    end else if (!sw_stop) begin
      if (state == ADCS_SAMPLE && timer == SAMPLE_CYC) begin
        bit_idx <= MSB_IDX;
        sar <= adcs_trial(MSB_IDX);
      end else if (state == ADCS_APPROX) begin
        // Keep or drop the trial bit, then try the next lower one
        if (bit_idx == lsb_idx) begin
          sar <= adcs_keep(sar, bit_idx, cmp_high);
        end else begin
          bit_idx <= bit_idx - 4'h1;
          sar <= adcs_keep(sar, bit_idx, cmp_high) |
                 adcs_trial(bit_idx - 4'h1);
        end
      end
    end
  end

  // Result register, stored before moving on
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      result <= 10'h000;
    end else if (stored) begin
      result <= res10 ? sar : (sar >> NARROW_LSB);
    end
  end

  // Unread flag: a new store wins over a simultaneous data read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      result_unread <= 1'b0;
    end else if (stored) begin
      result_unread <= 1'b1;
    end else if (rd_acc && avs_address == `ADCS_REG_DATA) begin
      result_unread <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status and interrupt: done and overrun sticky, write one to clear, set wins

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status <= 3'h0;
    end else begin
      if (stored) begin
        status[`ADCS_ST_DONE] <= 1'b1;
      end else if (wr_acc && avs_address == `ADCS_REG_STAT &&
                   avs_writedata[`ADCS_ST_DONE]) begin
        status[`ADCS_ST_DONE] <= 1'b0;
      end
      if (conv_done && !stored) begin
        status[`ADCS_ST_OVR] <= 1'b1;
      end else if (wr_acc && avs_address == `ADCS_REG_STAT &&
                   avs_writedata[`ADCS_ST_OVR]) begin
        status[`ADCS_ST_OVR] <= 1'b0;
      end
      status[`ADCS_ST_BUSY] <= (state != ADCS_IDLE);
    end
  end

  // Level interrupt; its done term alone is the request to the descriptor transfer service
  assign irq = |(status[1:0] & mask[1:0]);
  assign descriptor_transfer_service = status[`ADCS_ST_DONE] &&
                                       mask[`ADCS_ST_DONE];

  // Front-end drive: channel and DAC code from flops, sample_hold decoded from state
  assign analog_channel = cur_chan;
  assign sample_hold = (state == ADCS_SAMPLE);
  assign dac_code = sar;

endmodule // adcs_sequencer

//--- verif/adcs_sequencer_properties.sv
`timescale 1ns/10ps
module adcs_seq_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic reload_timer_out,
  input wire logic freerun_zero,
  input wire logic cmp_high,
  input wire logic [2:0] analog_channel,
  input wire logic sample_hold,
  input wire logic [9:0] dac_code,
  input wire logic irq,
  input wire logic descriptor_transfer_service
);
  logic [15:0] samp_cnt;
  logic [15:0] conv_cnt;
  logic seen;
  logic stop_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  // Length of the present sampling window
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      samp_cnt <= 16'h0000;
    end else begin
      samp_cnt <= sample_hold ? samp_cnt + 16'h0001 : 16'h0000;
    end
  end
  // Start-to-start distance; saturates so long idles never wrap
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_cnt <= 16'h0000;
      seen <= 1'b0;
    end else if (sample_hold && samp_cnt == 16'h0000) begin
      conv_cnt <= 16'h0001;
      seen <= 1'b1;
    end else if (conv_cnt != 16'hFFFF) begin
      conv_cnt <= conv_cnt + 16'h0001;
    end
  end
  // A stop command may legally cut a sampling window short
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stop_q <= 1'b0;
    end else begin
      stop_q <= avs_write && avs_address == 4'h5 && avs_writedata[1];
    end
  end
  ////////////////////////////////////////
  read_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest)
    else $error("read not held off");
  wait_once_a: assert property (
    avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("read wait too long");
  write_free_a: assert property (avs_write |-> !avs_waitrequest)
    else $error("write was held off");
  sample_len_a: assert property (
    !sample_hold && samp_cnt != 16'h0000 && !stop_q |->
    samp_cnt >= 16'h00FA)
    else $error("sampling too short");
  conv_len_a: assert property (
    sample_hold && samp_cnt == 16'h0000 && seen |-> conv_cnt >= 16'h02FF)
    else $error("conversion too short");
  chan_hold_a: assert property (
    sample_hold && $past(sample_hold) |-> $stable(analog_channel))
    else $error("channel moved while sampling");
  xfer_irq_a: assert property (descriptor_transfer_service |-> irq)
    else $error("transfer request without irq");
  reset_quiet_a: assert property (
    $rose(rst_b) |-> !sample_hold && !irq && dac_code == 10'h000)
    else $error("outputs busy after reset");
endmodule // adcs_seq_checker

//--- verif/adcs_front_model.sv
`timescale 1ns/10ps
// Analog side: track-and-hold feeding an ideal comparator
module adcs_front_model (
  input wire logic clk,
  input wire logic sample_hold,
  input wire logic [2:0] analog_channel,
  input wire logic [9:0] dac_code,
  input wire logic [79:0] levels,
  output logic cmp_high
);
  logic [9:0] held;
  // Tracks the chosen input while sampling, frozen otherwise
  always_ff @(posedge clk) begin
    if (sample_hold) begin
      held <= levels[analog_channel*10 +: 10];
    end
  end
  // No offset or noise: results are exact
  assign cmp_high = (held >= dac_code);
endmodule // adcs_front_model

//--- verif/tb_adcs_sequencer.sv
`timescale 1ns/10ps
module tb_adcs_sequencer;
  import adcs_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic reload_timer_out = 1'b0;
  logic freerun_zero = 1'b0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic cmp_high;
  logic [2:0] analog_channel;
  logic sample_hold;
  logic [9:0] dac_code;
  logic irq;
  logic descriptor_transfer_service;
  logic [79:0] levels = 80'h0;
  logic [31:0] rd_v;
  logic [9:0] old_v;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  int lo;
  adcs_sequencer dut_u (.clk, .rst_b, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .reload_timer_out,
    .freerun_zero, .cmp_high, .analog_channel, .sample_hold, .dac_code,
    .irq, .descriptor_transfer_service);
  adcs_front_model front_u (.clk, .sample_hold, .analog_channel, .dac_code,
    .levels, .cmp_high);
  // Clock, and a ceiling on the whole run
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      close_out();
    end
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, exp, input string what);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(bit wr, logic [3:0] a, logic [31:0] d);
    int n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) err_total++;
    rd_v = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // Poll status until a result is stored
  task automatic wait_done();
    int n = 0;
    do begin
      bus(0, 4'h2, 0);
      n++;
    end while (rd_v[0] !== 1'b1 && n < 1500);
    chk(rd_v[0], 1, "done");
  endtask
  // Hardware trigger: a rising edge held a few cycles
  task automatic kick(bit fz);
    @(posedge clk);
    freerun_zero <= fz;
    reload_timer_out <= !fz;
    repeat (4) @(posedge clk);
    freerun_zero <= 1'b0;
    reload_timer_out <= 1'b0;
  endtask
  // Narrow results keep the top eight bits
  function automatic logic [31:0] want(int c, bit r10);
    logic [9:0] v;
    v = levels[c*10 +: 10];
    return r10 ? {22'h0, v} : {24'h0, v[9:2]};
  endfunction
  function automatic logic [31:0] ctl(bit r, logic [1:0] m, t, bit p);
    return {26'h0, p, t, m, r};
  endfunction
  function automatic logic [31:0] chans(int l, int h);
    return {25'h0, h[2:0], 1'b0, l[2:0]};
  endfunction
  // Random levels with full-scale and zero corners
  task automatic new_levels();
    for (int i = 0; i < 8; i++) levels[i*10 +: 10] = 10'($urandom);
    levels[9:0] = 10'h3FF;
    levels[79:70] = 10'h000;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'h1E413E91));
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 16; a++) begin
      bus(0, a[3:0], 0);
      chk(rd_v, 0, "reset read");
    end
    $display("test reset done");
    // One channel per trigger source, irq unmasked
    bus(1, 4'h3, 1);
    for (int t = 0; t < 3; t++) begin
      new_levels();
      lo = (t == 2) ? 0 : $urandom_range(0, 7);
      bus(1, 4'h1, chans(lo, lo));
      bus(1, 4'h0, ctl(1, t[1:0] == 1 ? ADCS_MODE_SINGLE2 :
        ADCS_MODE_SINGLE1, t[1:0], 0));
      if (t == 0) bus(1, 4'h5, 1);
      else kick(t == 2);
      wait_done();
      chk(irq, 1, "irq");
      chk(descriptor_transfer_service, 1, "xfer");
      bus(0, 4'h4, 0);
      chk(rd_v, want(lo, 1), "data");
      bus(1, 4'h2, 1);
      repeat (2) @(negedge clk);
      chk(irq, 0, "irq cleared");
      repeat (800) @(posedge clk);
      bus(0, 4'h2, 0);
      chk(rd_v, 0, "stopped");
    end
    $display("test single done");
    // Eight-bit scan, masked irq
    new_levels();
    lo = $urandom_range(0, 4);
    bus(1, 4'h3, 0);
    bus(1, 4'h1, chans(lo, lo + 3));
    bus(1, 4'h0, ctl(0, ADCS_MODE_SINGLE2, ADCS_TRIG_SW, 0));
    bus(1, 4'h5, 1);
    for (int c = lo; c <= lo + 3; c++) begin
      wait_done();
      chk(irq, 0, "masked");
      bus(0, 4'h4, 0);
      chk(rd_v, want(c, 0), "scan");
      bus(1, 4'h2, 1);
    end
    repeat (800) @(posedge clk);
    bus(0, 4'h2, 0);
    chk(rd_v, 0, "scan end");
    $display("test scan done");
    // Incremental: one channel per trigger, then a pause
    bus(1, 4'h3, 1);
    lo = $urandom_range(0, 6);
    bus(1, 4'h1, chans(lo, lo + 1));
    bus(1, 4'h0, ctl(1, ADCS_MODE_INCR, ADCS_TRIG_RELOAD, 0));
    for (int c = lo; c <= lo + 1; c++) begin
      kick(0);
      wait_done();
      bus(0, 4'h4, 0);
      chk(rd_v, want(c, 1), "step");
      bus(1, 4'h2, 1);
      repeat (800) @(posedge clk);
      bus(0, 4'h2, 0);
      chk(rd_v, 32'h4, "paused");
    end
    bus(1, 4'h5, 2);
    $display("test incremental done");
    // Continuous with protection: unread data survives
    bus(1, 4'h1, chans(3, 3));
    bus(1, 4'h0, ctl(1, ADCS_MODE_CONT, ADCS_TRIG_SW, 1));
    bus(1, 4'h5, 1);
    wait_done();
    old_v = want(3, 1);
    levels[39:30] = ~old_v;
    repeat (1600) @(posedge clk);
    bus(0, 4'h2, 0);
    chk(rd_v[1:0], 2'b11, "overrun");
    bus(1, 4'h2, 3);
    bus(0, 4'h4, 0);
    chk(rd_v, old_v, "kept");
    wait_done();
    bus(0, 4'h4, 0);
    chk(rd_v, want(3, 1), "repeat");
    bus(1, 4'h5, 2);
    repeat (800) @(posedge clk);
    bus(0, 4'h2, 0);
    chk(rd_v[2], 0, "halted");
    $display("test continuous done");
    close_out();
  end
endmodule // tb_adcs_sequencer

bind adcs_sequencer adcs_seq_checker chk_u (.clk, .rst_b, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
  .reload_timer_out, .freerun_zero, .cmp_high, .analog_channel,
  .sample_hold, .dac_code, .irq, .descriptor_transfer_service);
